// [src/ivps_select.sv]
// Purpose: interrupt vector and priority select for a small cpu core
// Assumes: request lines are held by peripheral flags on clk_sys until serviced
// Notes:   one registered winner per cycle; losers simply stay pending
//
// Summary of operation
// - vector address is twice the vector number
// - reset 0, nmi 3, break 5, highest
// - other sources use 2-bit priority fields
// - higher level outranks lower level
// - equal levels resolve by vector order
// - sources of one module share one level
// - external pins on vectors 6 to 10
// - wakeup pins on vectors 11 to 18
// - clock sources on vectors 19 to 26
// - watchdog 27, event counter 28
// - pulse timer channel 1 on 29-31
// - pulse timer channel 2 on 32-34
// - dual timer halves on 35 and 36
// - serial units 37-39, two-wire bus 40
// - conversion end 42, sleep transition 43
// - field 00, 01, 1x give levels 0-2
// - mask select holds low levels pending
// - global mask holds all but reset/nmi/break
// - only the best request is presented
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module ivps_select #(
    parameter int NUM_VEC = ivps_pkg::NUM_VEC   // number of vector slots
) (
    input  wire logic                         clk_sys,      // system clock, 125 MHz
    input  wire logic                         sys_rst,      // synchronous reset, high
    input  wire logic [NUM_VEC-1:0]           src_req,      // request per vector number
    input  wire logic                         cpu_mask,     // global mask bit of the cpu
    input  wire logic [ivps_pkg::ADDR_W-1:0]  reg_addr,     // register address
    input  wire logic [ivps_pkg::DATA_W-1:0]  reg_wdata,    // register write data
    input  wire logic                         reg_wr,       // write strobe
    input  wire logic                         reg_rd,       // read strobe
    output logic      [ivps_pkg::DATA_W-1:0]  reg_rdata,    // read data, cycle after strobe
    output logic                              irq_pending,  // a request is presented
    output logic      [ivps_pkg::VEC_W-1:0]   irq_vector,   // winning vector number
    output logic      [ivps_pkg::VADDR_W-1:0] irq_vec_addr, // winning vector address
    output logic      [1:0]                   irq_rank      // rank of the winner
);

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    logic [ivps_pkg::DATA_W-1:0]  prio_reg [ivps_pkg::NUM_PRIO];  // priority_reg_a..e
    logic [ivps_pkg::DATA_W-1:0]  prio_next [ivps_pkg::NUM_PRIO]; // next values
    logic [1:0]                   mask_select_reg;                // {hi, lo}
    logic [1:0]                   mask_select_next;
    logic [ivps_pkg::DATA_W-1:0]  rdata_reg;                      // read return
    logic [ivps_pkg::DATA_W-1:0]  rdata_next;

    // decode of the register port
    logic                         wr_prio_a;     // write to priority_reg_a
    logic                         wr_prio_b;     // write to priority_reg_b
    logic                         wr_prio_c;     // write to priority_reg_c
    logic                         wr_prio_d;     // write to priority_reg_d
    logic                         wr_prio_e;     // write to priority_reg_e
    logic                         wr_mask_sel;   // write to mask_select_reg
    logic [ivps_pkg::DATA_W-1:0]  mask_sel_view; // mask select as read back
    logic [ivps_pkg::DATA_W-1:0]  status_view;   // live selector state
    logic [ivps_pkg::DATA_W-1:0]  rd_mux;        // addressed read value

    // per-vector selector inputs
    logic [NUM_VEC-1:0]           live_req;      // requests on assigned vectors
    logic [NUM_VEC-1:0]           eligible;      // passes all masking
    logic [1:0]                   rank [NUM_VEC];

    // selector result
    logic                         win_found;
    logic [ivps_pkg::VEC_W-1:0]   win_vec;
    logic [1:0]                   win_rank;

    // registered presentation
    logic                         pend_reg;
    logic [ivps_pkg::VEC_W-1:0]   vec_reg;
    logic [ivps_pkg::VADDR_W-1:0] vaddr_reg;
    logic [1:0]                   rank_reg;
    logic [ivps_pkg::VADDR_W-1:0] vaddr_next;

    // ------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------
    assign wr_prio_a   = reg_wr && (reg_addr == ivps_pkg::OFS_PRIO_A);
    assign wr_prio_b   = reg_wr && (reg_addr == ivps_pkg::OFS_PRIO_B);
    assign wr_prio_c   = reg_wr && (reg_addr == ivps_pkg::OFS_PRIO_C);
    assign wr_prio_d   = reg_wr && (reg_addr == ivps_pkg::OFS_PRIO_D);
    assign wr_prio_e   = reg_wr && (reg_addr == ivps_pkg::OFS_PRIO_E);
    assign wr_mask_sel = reg_wr && (reg_addr == ivps_pkg::OFS_MASK_SEL);

    assign prio_next[0] = wr_prio_a ? reg_wdata : prio_reg[0];
    assign prio_next[1] = wr_prio_b ? reg_wdata : prio_reg[1];
    assign prio_next[2] = wr_prio_c ? reg_wdata : prio_reg[2];
    assign prio_next[3] = wr_prio_d ? reg_wdata : prio_reg[3];
    // low nibble of the last register is reserved and holds zero
    assign prio_next[4] = wr_prio_e ? (reg_wdata & ivps_pkg::PRIO_E_WMASK) : prio_reg[4];

    // mask select keeps only its two live bits
    assign mask_select_next = wr_mask_sel ? reg_wdata[1:0] : mask_select_reg;

    // ------------------------------------------------------------------
    // read side
    // ------------------------------------------------------------------
    // upper bits of the mask select register always read as ones
    assign mask_sel_view = {ivps_pkg::MASK_SEL_ONES, mask_select_reg};

    // status: presented flag, then the vector number
    assign status_view = {pend_reg, 1'b0, vec_reg};

    // read multiplexer; unmapped offsets return zero
    assign rd_mux =
        (reg_addr == ivps_pkg::OFS_PRIO_A)   ? prio_reg[0]   :
        (reg_addr == ivps_pkg::OFS_PRIO_B)   ? prio_reg[1]   :
        (reg_addr == ivps_pkg::OFS_PRIO_C)   ? prio_reg[2]   :
        (reg_addr == ivps_pkg::OFS_PRIO_D)   ? prio_reg[3]   :
        (reg_addr == ivps_pkg::OFS_PRIO_E)   ? prio_reg[4]   :
        (reg_addr == ivps_pkg::OFS_MASK_SEL) ? mask_sel_view :
        (reg_addr == ivps_pkg::OFS_STATUS)   ? status_view   :
        '0;

    // read data is valid only in the cycle after the strobe
    assign rdata_next = reg_rd ? rd_mux : '0;

    // register file and read return
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            // all priority fields clear, all interrupts accepted
            for (int i = 0; i < ivps_pkg::NUM_PRIO; i++) begin
                prio_reg[i] <= ivps_pkg::PRIO_RST;
            end
            mask_select_reg <= ivps_pkg::MASK_SEL_RST;
            rdata_reg       <= '0;
        end else begin
            for (int i = 0; i < ivps_pkg::NUM_PRIO; i++) begin
                prio_reg[i] <= prio_next[i];
            end
            mask_select_reg <= mask_select_next;
            rdata_reg       <= rdata_next;
        end
    end

    // ------------------------------------------------------------------
    // per-vector level decode
    // ------------------------------------------------------------------
    // unassigned slots are never requested
    assign live_req = src_req & ~ivps_pkg::RESERVED_VECS;

    generate
        for (genvar g = 0; g < NUM_VEC; g++) begin : g_vec
            localparam logic [4:0] FID   = ivps_pkg::field_of(g);
            localparam int         REG_I = int'(FID[4:2]);
            localparam int         HI    = ivps_pkg::FIELD_TOP - 2 * int'(FID[1:0]);
            // timer channel 1 shares one field
            // timer channel 2 shares one field
            // dual timer halves share one field
            logic [1:0] field;     // raw field for this vector
            logic       fixed_src; // reset, nmi or break
            logic       nmi_brk;   // ignores the global mask

            assign field     = prio_reg[REG_I][HI -: 2];
            assign fixed_src = ivps_pkg::FIXED_VECS[g];
            // nmi and break pass the global mask
            assign nmi_brk   = (g == int'(ivps_pkg::VEC_NMI)) ||
                               (g == int'(ivps_pkg::VEC_BREAK));

            ivps_level_dec u_dec (
                .req        (live_req[g]),
                .is_fixed   (fixed_src),
                .is_nmi_brk (nmi_brk),
                .field      (field),
                .cpu_mask   (cpu_mask),
                .mask_sel   (mask_select_reg),
                .eligible   (eligible[g]),
                .rank       (rank[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // winner selection
    // ------------------------------------------------------------------
    // scan from the highest vector down; ties go to the later, lower vector
    always_comb begin
        win_found = 1'b0;
        win_vec   = '0;
        win_rank  = ivps_pkg::LVL_0;
        for (int v = NUM_VEC - 1; v >= 0; v--) begin
            if (eligible[v] && (!win_found || (rank[v] >= win_rank))) begin
                win_found = 1'b1;
                win_vec   = v[ivps_pkg::VEC_W-1:0];
                win_rank  = rank[v];
            end
        end
    end

    // local copy of the address width, declared before its use in the cast
    localparam int VADDR_W = ivps_pkg::VADDR_W;

    assign vaddr_next = ivps_pkg::VEC_BASE +
                        (VADDR_W'(win_vec) << ivps_pkg::VEC_SHIFT);

    // present only the winner, keep others pending
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            // nothing presented until the first evaluation
            pend_reg  <= 1'b0;
            vec_reg   <= '0;
            vaddr_reg <= '0;
            rank_reg  <= ivps_pkg::LVL_0;
        end else begin
            pend_reg  <= win_found;
            vec_reg   <= win_vec;
            vaddr_reg <= win_found ? vaddr_next : '0;
            rank_reg  <= win_rank;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign reg_rdata    = rdata_reg;
    assign irq_pending  = pend_reg;
    assign irq_vector   = vec_reg;
    assign irq_vec_addr = vaddr_reg;
    assign irq_rank     = rank_reg;

endmodule // ivps_select

// [src/ivps_pkg.sv]
// Purpose: shared constants for the interrupt vector and priority select block
// Assumes: 8-bit register port, one request line per vector number
// Notes:   field codes pack a register index and a 2-bit slot inside it
package ivps_pkg;

    // geometry of the vector space
    localparam int NUM_VEC    = 44;
    localparam int VEC_W      = 6;
    localparam int ADDR_W     = 3;
    localparam int DATA_W     = 8;
    localparam int VADDR_W    = 16;
    localparam int NUM_PRIO   = 5;

    // register offsets on the plain register port
    localparam logic [ADDR_W-1:0] OFS_PRIO_A   = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_PRIO_B   = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_PRIO_C   = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_PRIO_D   = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_PRIO_E   = 3'h4;
    localparam logic [ADDR_W-1:0] OFS_MASK_SEL = 3'h5;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 3'h6;

    // reset values and fixed read patterns
    localparam logic [DATA_W-1:0] PRIO_RST      = 8'h00;
    localparam logic [DATA_W-1:0] PRIO_E_WMASK  = 8'hf0;
    localparam logic [1:0]        MASK_SEL_RST  = 2'h0;
    localparam logic [5:0]        MASK_SEL_ONES = 6'h3f;

    // vector numbers with a fixed role
    localparam logic [VEC_W-1:0] VEC_RESET = 6'h00;
    localparam logic [VEC_W-1:0] VEC_NMI   = 6'h03;
    localparam logic [VEC_W-1:0] VEC_BREAK = 6'h05;
    localparam logic [VEC_W-1:0] VEC_LAST  = 6'h2b;

    // vector address = base + vector number shifted by one (one 16-bit word each)
    localparam logic [VADDR_W-1:0] VEC_BASE  = 16'h0000;
    localparam int                 VEC_SHIFT = 1;

    // vectors no source drives, and vectors with no programmable level
    localparam logic [NUM_VEC-1:0] RESERVED_VECS = 44'h200_0000_0016;
    localparam logic [NUM_VEC-1:0] FIXED_VECS    = 44'h000_0000_0029;

    // ranks used by the selector; fixed sources sit above level 2
    localparam logic [1:0] LVL_0     = 2'h0;
    localparam logic [1:0] LVL_1     = 2'h1;
    localparam logic [1:0] LVL_2     = 2'h2;
    localparam logic [1:0] LVL_FIXED = 2'h3;

    // top bit of the first slot inside a priority register
    localparam int FIELD_TOP = 7;

    // field code {register index, slot}; slot 0 is bits 7-6, slot 3 is bits 1-0
    function automatic logic [4:0] field_of(input int v);
        logic [4:0] f;
        f = 5'h00;
        if (v == 6)                 f = 5'h00;
        else if (v == 7)            f = 5'h01;
        else if (v == 8)            f = 5'h02;
        else if (v == 9 || v == 10) f = 5'h03;
        else if (v <= 18)           f = 5'h04;
        else if (v <= 26)           f = 5'h05;
        else if (v == 27)           f = 5'h06;
        else if (v == 28)           f = 5'h07;
        else if (v <= 31)           f = 5'h08;
        else if (v <= 34)           f = 5'h09;
        else if (v <= 36)           f = 5'h0a;
        else if (v == 37)           f = 5'h0b;
        else if (v == 38)           f = 5'h0c;
        else if (v == 39)           f = 5'h0d;
        else if (v == 40)           f = 5'h0e;
        else if (v == 42)           f = 5'h10;
        else if (v == 43)           f = 5'h11;
        return f;
    endfunction

endpackage

// [src/ivps_level_dec.sv]
// Purpose: per-vector level decode and acceptance check
// Assumes: requests and mask state are on clk_sys, no crossing here
// Notes:   purely combinational, one instance per vector number
`timescale 1ns/100ps
module ivps_level_dec (
    input  wire logic       req,        // pending request of this vector
    input  wire logic       is_fixed,   // reset, nmi or address break
    input  wire logic       is_nmi_brk, // survives the global cpu mask
    input  wire logic [1:0] field,      // raw 2-bit priority field
    input  wire logic       cpu_mask,   // global cpu mask bit
    input  wire logic [1:0] mask_sel,   // {mask_select_hi, mask_select_lo}
    output logic            eligible,   // may be presented to the cpu
    output logic [1:0]      rank        // rank used by the selector
);

    logic [1:0] level;      // decoded programmable level
    logic       lvl_ok;     // level passes the mask select
    logic       global_ok;  // passes the global cpu mask

    assign level = field[1] ? ivps_pkg::LVL_2 :
                   (field[0] ? ivps_pkg::LVL_1 : ivps_pkg::LVL_0);

    assign lvl_ok = mask_sel[1] ? (level == ivps_pkg::LVL_2) :
                    (mask_sel[0] ? (level != ivps_pkg::LVL_0) : 1'b1);

    // global mask spares nmi and break
    assign global_ok = !cpu_mask || is_nmi_brk;

    // fixed sources skip the level check and rank highest
    assign rank     = is_fixed ? ivps_pkg::LVL_FIXED : level;
    assign eligible = req && (is_fixed ? (global_ok || !is_nmi_brk) : (lvl_ok && global_ok));

endmodule // ivps_level_dec

// [bench/ivps_select_monitor.sv]
// Purpose: port-level checks for the vector select block
// Assumes: one clock domain, synchronous active-high reset
// Notes:   mask select is shadowed from register writes
`timescale 1ns/100ps
module ivps_select_monitor #(
    parameter int NUM_VEC = ivps_pkg::NUM_VEC // number of vector slots
) (
    input wire logic                         clk_sys,
    input wire logic                         sys_rst,
    input wire logic [NUM_VEC-1:0]           src_req,
    input wire logic                         cpu_mask,
    input wire logic [ivps_pkg::ADDR_W-1:0]  reg_addr,
    input wire logic [ivps_pkg::DATA_W-1:0]  reg_wdata,
    input wire logic                         reg_wr,
    input wire logic                         reg_rd,
    input wire logic [ivps_pkg::DATA_W-1:0]  reg_rdata,
    input wire logic                         irq_pending,
    input wire logic [ivps_pkg::VEC_W-1:0]   irq_vector,
    input wire logic [ivps_pkg::VADDR_W-1:0] irq_vec_addr,
    input wire logic [1:0]                   irq_rank
);
    logic [NUM_VEC-1:0] req_q;  // requests one edge ago
    logic [1:0]         msel_q; // shadow of mask select
    // shadows so outputs can be tied to their causes
    always_ff @(posedge clk_sys) begin
        req_q <= src_req;
        if (sys_rst)
            msel_q <= 2'h0;
        else if (reg_wr && reg_addr == ivps_pkg::OFS_MASK_SEL)
            msel_q <= reg_wdata[1:0];
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // read of the mask select register
    sequence mask_rd_s;
        reg_rd && reg_addr == ivps_pkg::OFS_MASK_SEL;
    endsequence
    // no read strobe in this cycle
    sequence idle_rd_s;
        !reg_rd;
    endsequence
    vec_addr_a: assert property (
        irq_pending |-> irq_vec_addr == {9'h000, irq_vector, 1'b0}) else $error("bad vec addr");
    fixed_rank_a: assert property (
        irq_pending |-> (irq_rank == 2'h3) == ivps_pkg::FIXED_VECS[irq_vector])
        else $error("fixed rank wrong");
    reset_wins_a: assert property (
        src_req[0] |=> irq_pending && irq_vector == 6'h00) else $error("reset not chosen");
    nmi_pass_a: assert property (
        src_req[3] && !src_req[0] |=> irq_vector == ivps_pkg::VEC_NMI) else $error("nmi lost");
    cpu_hold_a: assert property (
        cpu_mask && (src_req & ivps_pkg::FIXED_VECS) == '0 |=> !irq_pending)
        else $error("cpu mask ignored");
    no_reserved_a: assert property (
        irq_pending |-> !ivps_pkg::RESERVED_VECS[irq_vector] && irq_vector <= 6'h2b)
        else $error("reserved vector out");
    only_req_a: assert property (
        irq_pending |-> req_q[irq_vector]) else $error("vector not requested");
    idle_in_a: assert property (
        (src_req & ~ivps_pkg::RESERVED_VECS) == '0 |=> !irq_pending
        ##0 irq_vector == 6'h00 && irq_vec_addr == 16'h0000) else $error("idle not clean");
    mask_level_a: assert property (
        irq_pending && irq_rank != 2'h3 |-> !$past(cpu_mask)
        && (!$past(msel_q[1]) || irq_rank == 2'h2) && ($past(msel_q) != 2'h1 || irq_rank != 2'h0))
        else $error("masked level shown");
    rd_mask_a: assert property (
        mask_rd_s |=> reg_rdata == {ivps_pkg::MASK_SEL_ONES, $past(msel_q)})
        else $error("mask select read");
    rd_idle_a: assert property (
        idle_rd_s |=> reg_rdata == 8'h00) else $error("read data not cleared");
endmodule // ivps_select_monitor
bind ivps_select ivps_select_monitor #(.NUM_VEC(NUM_VEC)) ivps_select_monitor_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .src_req(src_req), .cpu_mask(cpu_mask),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq_pending(irq_pending), .irq_vector(irq_vector),
    .irq_vec_addr(irq_vec_addr), .irq_rank(irq_rank));

// [bench/ivps_cpu_model.sv]
// Purpose: cpu core side: global mask bit and presented-vector log
// Assumes: same clock as the select block
// Notes:   mask bit follows the bench request one edge later
`timescale 1ns/100ps
module ivps_cpu_model (
    input  wire logic                       clk_sys,     // system clock
    input  wire logic                       sys_rst,     // synchronous reset
    input  wire logic                       mask_req,    // bench asks for the i bit
    input  wire logic                       irq_pending, // request presented
    input  wire logic [ivps_pkg::VEC_W-1:0] irq_vector,  // presented vector
    output logic                            cpu_mask,    // global mask bit
    output logic      [ivps_pkg::VEC_W-1:0] seen_vec     // last presented vector
);
    // condition register i bit and log of the last presentation
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cpu_mask <= 1'b0;
            seen_vec <= 6'h00;
        end else begin
            cpu_mask <= mask_req;
            if (irq_pending)
                seen_vec <= irq_vector;
        end
    end
endmodule // ivps_cpu_model

// [bench/tb_interrupt_vector_priority_select.sv]
// Purpose: self-checking bench for the vector select block
// Assumes: 125 MHz clock, reset held 16 cycles
// Notes:   expectations come from the vector table, not the design
`timescale 1ns/100ps
module tb_interrupt_vector_priority_select;
    logic        clk_sys, sys_rst, mask_req, cpu_mask, reg_wr, reg_rd, irq_pending;
    logic [43:0] src_req;
    logic [2:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata;
    logic [5:0]  irq_vector, seen_vec;
    logic [15:0] irq_vec_addr;
    logic [1:0]  irq_rank;
    int          n_fail, checks;
    int          first_vec [17] = '{6,7,8,9,11,19,27,28,29,32,35,37,38,39,40,42,43};
    // 8 ns clock
    always #4 clk_sys = ~clk_sys;
    ivps_select ivps_select_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .src_req(src_req),
        .cpu_mask(cpu_mask), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_pending(irq_pending),
        .irq_vector(irq_vector), .irq_vec_addr(irq_vec_addr), .irq_rank(irq_rank));
    ivps_cpu_model ivps_cpu_model_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .mask_req(mask_req), .irq_pending(irq_pending), .irq_vector(irq_vector),
        .cpu_mask(cpu_mask), .seen_vec(seen_vec));
    function automatic logic [43:0] b(int v);
        return 44'h1 << v;
    endfunction
    task automatic chk(string what, logic [15:0] got, logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [2:0] a, logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [2:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // hold a request pattern, let mask model and select register settle
    task automatic go(logic [43:0] r);
        @(posedge clk_sys);
        src_req <= r;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    task automatic expq(logic p, int v, logic [1:0] rk);
        chk("pending", irq_pending, p);
        chk("vector", irq_vector, p ? 16'(v) : 16'h0);
        chk("address", irq_vec_addr, p ? 16'(2 * v) : 16'h0);
        if (p)
            chk("rank", irq_rank, rk);
    endtask
    task automatic t_regs();
        logic [7:0] d;
        for (int a = 0; a < 5; a++) begin
            rd(3'(a), d);
            chk("prio reset", d, 8'h00);
        end
        rd(ivps_pkg::OFS_MASK_SEL, d);
        chk("mask reset", d, 8'hfc);
        wr(3'h0, 8'ha5);
        rd(3'h0, d);
        chk("prio a", d, 8'ha5);
        wr(3'h4, 8'hff);
        rd(3'h4, d);
        chk("prio e", d, 8'hf0);
        wr(3'h7, 8'hff);
        rd(3'h7, d);
        chk("unmapped", d, 8'h00);
        wr(3'h0, 8'h00);
        wr(3'h4, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_vectors();
        logic [7:0] d;
        bit         rsv, fx;
        for (int v = 0; v < 44; v++) begin
            rsv = (v == 1 || v == 2 || v == 4 || v == 41);
            fx = (v == 0 || v == 3 || v == 5);
            go(b(v));
            expq(!rsv, v, fx ? 2'h3 : 2'h0);
        end
        go(b(6));
        rd(ivps_pkg::OFS_STATUS, d);
        chk("status", d, 8'h86);
        $display("test vectors done");
    endtask
    task automatic t_fields();
        int idx;
        wr(ivps_pkg::OFS_MASK_SEL, 8'h02);
        for (int g = 0; g < 17; g++) begin
            idx = (g < 15) ? g : g + 1;
            for (int r = 0; r < 5; r++)
                wr(3'(r), (r == idx / 4) ? ((g % 2 ? 8'h80 : 8'hc0) >> (2 * (idx % 4))) : 8'h00);
            go(~(ivps_pkg::FIXED_VECS | ivps_pkg::RESERVED_VECS));
            expq(1'b1, first_vec[g], 2'h2);
        end
        wr(3'h4, 8'h00);
        wr(ivps_pkg::OFS_MASK_SEL, 8'h00);
        $display("test fields done");
    endtask
    task automatic t_levels();
        wr(3'h4, 8'h60);
        go(b(6) | b(42) | b(43));
        expq(1'b1, 43, 2'h2);
        chk("cpu saw", seen_vec, 16'd43);
        go(b(6) | b(42));
        expq(1'b1, 42, 2'h1);
        wr(ivps_pkg::OFS_MASK_SEL, 8'h01);
        go(b(6));
        expq(1'b0, 0, 2'h0);
        go(b(6) | b(42));
        expq(1'b1, 42, 2'h1);
        wr(ivps_pkg::OFS_MASK_SEL, 8'h02);
        go(b(42));
        expq(1'b0, 0, 2'h0);
        mask_req <= 1'b1;
        go(b(43) | b(5));
        expq(1'b1, 5, 2'h3);
        go(b(43));
        expq(1'b0, 0, 2'h0);
        go(b(0) | b(3) | b(43));
        expq(1'b1, 0, 2'h3);
        mask_req <= 1'b0;
        wr(ivps_pkg::OFS_MASK_SEL, 8'h00);
        wr(3'h4, 8'h50);
        wr(3'h0, 8'h40);
        go(b(6) | b(42) | b(43));
        expq(1'b1, 6, 2'h1);
        go(b(3) | b(42) | b(43));
        expq(1'b1, 3, 2'h3);
        go(b(42) | b(43));
        expq(1'b1, 42, 2'h1);
        $display("test levels done");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // main sequence
    initial begin
        clk_sys = 1'b0;
        sys_rst = 1'b1;
        mask_req = 1'b0;
        src_req = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_regs();
        t_vectors();
        t_fields();
        t_levels();
        wrap_up();
    end
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        wrap_up();
    end
endmodule // tb_interrupt_vector_priority_select
